// ==== core/ckss_switch_ctrl.sv ====
// system clock source switch sequencer with axi4-lite registers
`timescale 1ns/10ps
`include "ckss_defs.svh"
// How it works
// - switching and monitor only when config bit 0
// - disabled: current source follows startup config
// - disabled: switch request forced and read 0
// - four oscillators selectable anytime by software
// - equal sources: clear request, abandon switch
// - valid switch clears lock and fail flags
// - start new oscillator, crystal waits timer
// - multiplier source waits for lock
// - count ten new-clock cycles, then hand over
// - done: clear request, copy requested to current
// - stop old oscillator except kept ones
// - bus stays serviced throughout the switch
// - config field picks secondary low-power mode
module ckss_switch_ctrl #(
	parameter int OST_TICKS = `CKSS_OST_TICKS,
	parameter int CNT_W     = 11
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   switch_enable_config_bit,
	input  wire logic [2:0]             startup_source_config,
	input  wire logic [1:0]             secondary_power_mode_field,
	input  wire logic                   watchdog_timer_en,
	input  wire logic [3:0]             osc_running,
	input  wire logic                   pll_lock,
	input  wire logic                   clock_fail,
	input  wire logic                   new_clk_toggle,
	output logic [3:0]                  osc_en,
	output logic                        pll_en,
	output ckss_pkg::ckss_src_t         sys_clk_src,
	output logic                        fail_safe_monitor_en,
	output logic                        secondary_low_power,
	output logic                        irq
);
	import ckss_pkg::*;

	localparam int NSYNC = 14;

	if (OST_TICKS < `CKSS_SETTLE_TICKS || OST_TICKS >= (1 << CNT_W))
	begin : g_bad_ost
		$error("crystal timer count does not fit the tick counter");
	end

	// ----------------------------------------
	// reset release and input synchronisers
	// ----------------------------------------
	logic [1:0]       rst_sync_q;
	logic             sync_rst_b;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] meta_q;
	logic [NSYNC-1:0] sync_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) rst_sync_q <= 2'h0;
		else rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign sync_rst_b = rst_sync_q[1];

	assign async_in = {new_clk_toggle, clock_fail, pll_lock, osc_running,
		switch_enable_config_bit, startup_source_config,
		secondary_power_mode_field, watchdog_timer_en};

	for (genvar i = 0; i < NSYNC; i++) begin : g_sync
		always_ff @(posedge ref_clk or negedge sync_rst_b) begin
			if (!sync_rst_b) begin
				meta_q[i] <= 1'b0;
				sync_q[i] <= 1'b0;
			end else begin
				meta_q[i] <= async_in[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	logic       tog_s;
	logic       fail_s;
	logic       lock_s;
	logic [3:0] run_s;
	assign tog_s  = sync_q[13];
	assign fail_s = sync_q[12];
	assign lock_s = sync_q[11];
	assign run_s  = sync_q[10:7];

	// ----------------------------------------
	// configuration capture after reset
	// ----------------------------------------
	// straps are frozen once the synchronisers have settled
	logic [1:0] cfg_cnt_q;
	logic       cfg_done_q;
	logic       cfg_dis_q;
	logic [2:0] cfg_start_q;
	logic [1:0] cfg_mode_q;
	logic       cfg_wdt_q;
	logic       sw_en;

	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			cfg_cnt_q  <= 2'h0;
			cfg_done_q <= 1'b0;
		end else if (!cfg_done_q) begin
			cfg_cnt_q  <= cfg_cnt_q + 2'h1;
			cfg_done_q <= cfg_cnt_q == 2'h3;
		end
	end

	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			cfg_dis_q   <= 1'b1;
			cfg_start_q <= 3'h0;
			cfg_mode_q  <= 2'h0;
			cfg_wdt_q   <= 1'b0;
		end else if (!cfg_done_q) begin
			cfg_dis_q   <= sync_q[6];
			cfg_start_q <= sync_q[5:3];
			cfg_mode_q  <= sync_q[2:1];
			cfg_wdt_q   <= sync_q[0];
		end
	end
	assign sw_en = cfg_done_q && !cfg_dis_q;

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	// one write and one read in flight; both serviced in every
	// sequencer state so software keeps running during a switch
	logic        aw_h_q;
	logic        w_h_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        wr_fire;
	logic        bvalid_d;
	logic        rvalid_d;
	logic        aw_h_d;
	logic        w_h_d;
	logic [31:0] rd_mux;
	logic        rd_ok;

	assign aw_take  = s_axi_awvalid && s_axi_awready;
	assign w_take   = s_axi_wvalid && s_axi_wready;
	assign ar_take  = s_axi_arvalid && s_axi_arready;
	assign wr_fire  = aw_h_q && w_h_q;
	assign bvalid_d = wr_fire || (s_axi_bvalid && !s_axi_bready);
	assign rvalid_d = ar_take || (s_axi_rvalid && !s_axi_rready);
	assign aw_h_d   = (aw_h_q || aw_take) && !wr_fire;
	assign w_h_d    = (w_h_q || w_take) && !wr_fire;

	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			aw_h_q        <= 1'b0;
			w_h_q         <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CKSS_RESP_OK;
		end else begin
			aw_h_q        <= aw_h_d;
			w_h_q         <= w_h_d;
			s_axi_awready <= !aw_h_d && !bvalid_d;
			s_axi_wready  <= !w_h_d && !bvalid_d;
			s_axi_bvalid  <= bvalid_d;
			if (aw_take) aw_addr_q <= s_axi_awaddr;
			if (w_take) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bresp <= (aw_addr_q <= `CKSS_OFF_CFG &&
					aw_addr_q[1:0] == 2'h0) ? `CKSS_RESP_OK
					: `CKSS_RESP_ERR;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CKSS_RESP_OK;
		end else begin
			s_axi_arready <= !rvalid_d;
			s_axi_rvalid  <= rvalid_d;
			if (ar_take) begin
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `CKSS_RESP_OK : `CKSS_RESP_ERR;
			end
		end
	end

	// ----------------------------------------
	// unlock keys
	// ----------------------------------------
	ckss_key_t   key_q;
	logic        wr_ctrl;
	logic        hi_only;
	logic        lo_only;
	logic        hi_open_wr;
	logic        lo_open_wr;
	logic [7:0]  wb_hi;
	logic [7:0]  wb_lo;

	assign wr_ctrl    = wr_fire && aw_addr_q == `CKSS_OFF_CTRL;
	assign hi_only    = w_strb_q == 4'h2;
	assign lo_only    = w_strb_q == 4'h1;
	assign wb_hi      = w_data_q[15:8];
	assign wb_lo      = w_data_q[7:0];
	assign hi_open_wr = wr_ctrl && w_strb_q[1] && key_q == KEY_HI_OPEN;
	assign lo_open_wr = wr_ctrl && w_strb_q[0] && key_q == KEY_LO_OPEN;

	// any access that is not the next step drops the key
	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) key_q <= KEY_NONE;
		else if (ar_take || (wr_fire && !wr_ctrl)) key_q <= KEY_NONE;
		else if (wr_ctrl) begin
			if (key_q == KEY_HI_OPEN || key_q == KEY_LO_OPEN)
				key_q <= KEY_NONE;
			else if (hi_only && key_q == KEY_HI_HALF &&
				wb_hi == `CKSS_KEY_H2)
				key_q <= KEY_HI_OPEN;
			else if (hi_only && wb_hi == `CKSS_KEY_H1)
				key_q <= KEY_HI_HALF;
			else if (lo_only && key_q == KEY_LO_HALF &&
				wb_lo == `CKSS_KEY_L2)
				key_q <= KEY_LO_OPEN;
			else if (lo_only && wb_lo == `CKSS_KEY_L1)
				key_q <= KEY_LO_HALF;
			else key_q <= KEY_NONE;
		end
	end

	// ----------------------------------------
	// switch sequencer
	// ----------------------------------------
	ckss_sw_t        st_q;
	logic [2:0]      req_q;
	logic [2:0]      tgt_q;
	ckss_src_t       cur_q;
	logic            swreq_q;
	logic            keep_q;
	logic            lock_q;
	logic            cf_q;
	logic            tog_q;
	logic            tick;
	logic            cnt_start;
	logic [CNT_W-1:0] cnt_target;
	logic            cnt_done;
	logic            sw_abort;
	logic            sw_begin;
	logic            sw_finish;
	logic            run_tgt;

	assign tick      = tog_s ^ tog_q;
	assign run_tgt   = run_s[osc_of(tgt_q)];
	assign sw_abort  = st_q == SW_IDLE && swreq_q && sw_en &&
		(req_q == cur_q || !src_valid(req_q));
	assign sw_begin  = st_q == SW_IDLE && swreq_q && sw_en && !sw_abort;
	assign sw_finish = st_q == SW_SETTLE && cnt_done;

	always_comb begin
		cnt_start  = 1'b0;
		cnt_target = CNT_W'(`CKSS_SETTLE_TICKS);
		case (st_q)
			SW_START: if (run_tgt) begin
				cnt_start = !uses_mul(tgt_q) || is_crystal(tgt_q);
				if (is_crystal(tgt_q)) cnt_target = CNT_W'(OST_TICKS);
			end
			SW_OST: begin
				// the length must stand for the whole wait, not only at start
				cnt_target = CNT_W'(OST_TICKS);
				cnt_start  = cnt_done && !uses_mul(tgt_q);
			end
			SW_LOCK: cnt_start = lock_s;
			default: cnt_start = 1'b0;
		endcase
	end

	ckss_tick_count #(.W(CNT_W)) u_ticks (
		.clk    (ref_clk),
		.rst_b  (sync_rst_b),
		.start  (cnt_start),
		.target (cnt_target),
		.tick   (tick),
		.done_q (cnt_done)
	);

	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			st_q  <= SW_IDLE;
			tgt_q <= 3'h0;
			tog_q <= 1'b0;
		end else begin
			tog_q <= tog_s;
			case (st_q)
				SW_IDLE: if (sw_begin) begin
					tgt_q <= req_q;
					st_q  <= SW_START;
				end
				SW_START: if (run_tgt) begin
					if (is_crystal(tgt_q)) st_q <= SW_OST;
					else if (uses_mul(tgt_q)) st_q <= SW_LOCK;
					else st_q <= SW_SETTLE;
				end
				SW_OST: if (cnt_done)
					st_q <= uses_mul(tgt_q) ? SW_LOCK : SW_SETTLE;
				SW_LOCK: if (lock_s) st_q <= SW_SETTLE;
				SW_SETTLE: if (cnt_done) st_q <= SW_IDLE;
				default: st_q <= SW_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			req_q   <= `CKSS_REQ_RST;
			cur_q   <= SRC_FAST_RC;
			swreq_q <= 1'b0;
			keep_q  <= 1'b0;
		end else begin
			if (hi_open_wr) req_q <= wb_hi[2:0];
			if (lo_open_wr) keep_q <= wb_lo[`CKSS_KEEP_BIT];
			if (!sw_en) cur_q <= ckss_src_t'(cfg_start_q);
			else if (sw_finish) cur_q <= ckss_src_t'(tgt_q);
			if (!sw_en) swreq_q <= 1'b0;
			else if (lo_open_wr && wb_lo[`CKSS_SWREQ_BIT])
				swreq_q <= 1'b1;
			else if (sw_abort || sw_finish) swreq_q <= 1'b0;
		end
	end

	// fail flag: a failure seen in the clearing cycle still sets
	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			lock_q <= 1'b0;
			cf_q   <= 1'b0;
		end else begin
			if (sw_begin) lock_q <= 1'b0;
			else if (sw_finish) lock_q <= lock_s && uses_mul(tgt_q);
			else lock_q <= lock_s && (uses_mul(cur_q) ||
				(st_q != SW_IDLE && uses_mul(tgt_q)));
			if (sw_en && fail_s) cf_q <= 1'b1;
			else if (sw_begin) cf_q <= 1'b0;
			else if (lo_open_wr && !wb_lo[`CKSS_CF_BIT]) cf_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// oscillator enables and outputs
	// ----------------------------------------
	logic [3:0] en_d;

	always_comb begin
		en_d = 4'h0;
		en_d[osc_of(cur_q)] = 1'b1;
		if (st_q != SW_IDLE) en_d[osc_of(tgt_q)] = 1'b1;
		if (cfg_wdt_q || sw_en) en_d[OSC_LOW_POWER_RC] = 1'b1;
		if (keep_q) en_d[OSC_SECONDARY] = 1'b1;
	end

	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			osc_en               <= 4'h0;
			pll_en               <= 1'b0;
			sys_clk_src          <= SRC_FAST_RC;
			fail_safe_monitor_en <= 1'b0;
			secondary_low_power  <= 1'b0;
		end else begin
			osc_en               <= en_d;
			pll_en               <= uses_mul(cur_q) ||
				(st_q != SW_IDLE && uses_mul(tgt_q));
			sys_clk_src          <= cur_q;
			fail_safe_monitor_en <= sw_en;
			secondary_low_power  <= cfg_mode_q == `CKSS_SECONDARY_OSCILLATOR_LP_MODE;
		end
	end

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	logic [`CKSS_EV_W-1:0] sts_q;
	logic [`CKSS_EV_W-1:0] mask_q;
	logic [`CKSS_EV_W-1:0] ev;
	logic                  wr_sts;

	assign ev[`CKSS_EV_DONE]  = sw_finish;
	assign ev[`CKSS_EV_ABORT] = sw_abort;
	assign ev[`CKSS_EV_FAIL]  = sw_en && fail_s && !cf_q;
	assign wr_sts = wr_fire && aw_addr_q == `CKSS_OFF_STS && w_strb_q[0];

	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) begin
			sts_q  <= '0;
			mask_q <= '0;
			irq    <= 1'b0;
		end else begin
			sts_q <= ev | (sts_q &
				~(wr_sts ? w_data_q[`CKSS_EV_W-1:0] : '0));
			if (wr_fire && aw_addr_q == `CKSS_OFF_MASK && w_strb_q[0])
				mask_q <= w_data_q[`CKSS_EV_W-1:0];
			irq <= |(sts_q & mask_q);
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (s_axi_araddr == `CKSS_OFF_CTRL) begin
			rd_mux[`CKSS_CUR_LSB +: 3]  = cur_q;
			rd_mux[`CKSS_REQ_LSB +: 3]  = req_q;
			rd_mux[`CKSS_LOCK_BIT]      = lock_q;
			rd_mux[`CKSS_CF_BIT]        = cf_q;
			rd_mux[`CKSS_KEEP_BIT]      = keep_q;
			rd_mux[`CKSS_SWREQ_BIT]     = swreq_q;
		end else if (s_axi_araddr == `CKSS_OFF_STS) begin
			rd_mux[`CKSS_EV_W-1:0] = sts_q;
		end else if (s_axi_araddr == `CKSS_OFF_MASK) begin
			rd_mux[`CKSS_EV_W-1:0] = mask_q;
		end else if (s_axi_araddr == `CKSS_OFF_CFG) begin
			rd_mux[7:0] = {st_q, cfg_mode_q, cfg_wdt_q, cfg_dis_q,
				1'b0};
			rd_mux[10:8] = cfg_start_q;
		end else rd_ok = 1'b0;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic [3:0] settle_q;
	always_ff @(posedge ref_clk or negedge sync_rst_b) begin
		if (!sync_rst_b) settle_q <= 4'h0;
		else if (cnt_start) settle_q <= 4'h0;
		else if (tick && st_q == SW_SETTLE && !cnt_done)
			settle_q <= settle_q + 4'h1;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!sync_rst_b);

	property p_dis_req;
		cfg_done_q && cfg_dis_q |=> !swreq_q && st_q == SW_IDLE;
	endproperty
	a_dis_req: assert property (p_dis_req)
		else $error("request bit set while switching disabled");

	property p_dis_cur;
		cfg_done_q && cfg_dis_q |=> cur_q == $past(cfg_start_q);
	endproperty
	a_dis_cur: assert property (p_dis_cur)
		else $error("current source not from startup config");

	property p_redundant;
		sw_abort |=> !swreq_q && st_q == SW_IDLE ##1 sts_q[1];
	endproperty
	a_redundant: assert property (p_redundant)
		else $error("redundant switch not abandoned");

	property p_begin_clears;
		sw_begin |=> !lock_q && st_q == SW_START;
	endproperty
	a_begin_clears: assert property (p_begin_clears)
		else $error("lock not cleared at switch start");

	property p_lock_wait;
		st_q == SW_LOCK && !lock_s |=> st_q == SW_LOCK;
	endproperty
	a_lock_wait: assert property (p_lock_wait)
		else $error("left lock wait without lock");

	property p_settle_ten;
		sw_finish |-> settle_q == 4'hA;
	endproperty
	a_settle_ten: assert property (p_settle_ten)
		else $error("handover not after ten new-clock ticks");

	property p_finish;
		sw_finish |=> cur_q == $past(tgt_q) && !swreq_q
			##1 sys_clk_src == $past(tgt_q, 2);
	endproperty
	a_finish: assert property (p_finish)
		else $error("finish did not copy source or clear request");

	property p_cur_on;
		$stable(cur_q) |=> osc_en[osc_of($past(cur_q))];
	endproperty
	a_cur_on: assert property (p_cur_on)
		else $error("current oscillator not enabled");

	property p_key_once;
		key_q == KEY_HI_OPEN && (wr_fire || ar_take) |=>
			key_q != KEY_HI_OPEN;
	endproperty
	a_key_once: assert property (p_key_once)
		else $error("unlock survived an access");

	property p_fsm_off;
		cfg_done_q |-> fail_safe_monitor_en == $past(sw_en);
	endproperty
	a_fsm_off: assert property (p_fsm_off)
		else $error("monitor enable wrong");

	c_done: cover property (sw_finish);
	c_abort: cover property (sw_abort);
	c_crystal: cover property (st_q == SW_OST ##[1:1000] sw_finish);
	c_mul: cover property (st_q == SW_LOCK ##1 st_q == SW_SETTLE);
endmodule // ckss_switch_ctrl

// ==== core/ckss_defs.svh ====
// offsets, field positions, key bytes and counts of the clock switch block
`ifndef CKSS_DEFS_SVH
`define CKSS_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CKSS_OFF_CTRL 8'h00
`define CKSS_OFF_STS 8'h04
`define CKSS_OFF_MASK 8'h08
`define CKSS_OFF_CFG 8'h0C
// ----------------------------------------
// control register fields
// ----------------------------------------
`define CKSS_CUR_LSB 12
`define CKSS_REQ_LSB 8
`define CKSS_LOCK_BIT 5
`define CKSS_CF_BIT 3
`define CKSS_KEEP_BIT 1
`define CKSS_SWREQ_BIT 0
`define CKSS_REQ_RST 3'h0
// ----------------------------------------
// unlock keys
// ----------------------------------------
`define CKSS_KEY_H1 8'h78
`define CKSS_KEY_H2 8'h9A
`define CKSS_KEY_L1 8'h46
`define CKSS_KEY_L2 8'h57
// ----------------------------------------
// event bits, counts, codes
// ----------------------------------------
`define CKSS_EV_DONE 0
`define CKSS_EV_ABORT 1
`define CKSS_EV_FAIL 2
`define CKSS_EV_W 3
`define CKSS_SETTLE_TICKS 10
`define CKSS_OST_TICKS 1024
`define CKSS_SECONDARY_OSCILLATOR_LP_MODE 2'h1
`define CKSS_RESP_OK 2'h0
`define CKSS_RESP_ERR 2'h2
`endif

// ==== core/ckss_pkg.sv ====
// types and source helpers of the clock switch block
package ckss_pkg;
	typedef enum logic [2:0] {
		SRC_FAST_RC      = 3'h0,
		SRC_FAST_RC_MUL  = 3'h1,
		SRC_PRIMARY      = 3'h2,
		SRC_PRIMARY_MUL  = 3'h3,
		SRC_SECONDARY    = 3'h4,
		SRC_LOW_POWER_RC = 3'h5
	} ckss_src_t;

	typedef enum logic [1:0] {
		OSC_PRIMARY      = 2'h0,
		OSC_SECONDARY    = 2'h1,
		OSC_FAST_RC      = 2'h2,
		OSC_LOW_POWER_RC = 2'h3
	} ckss_osc_t;

	typedef enum logic [2:0] {
		SW_IDLE   = 3'h0,
		SW_START  = 3'h1,
		SW_OST    = 3'h2,
		SW_LOCK   = 3'h3,
		SW_SETTLE = 3'h4
	} ckss_sw_t;

	typedef enum logic [2:0] {
		KEY_NONE    = 3'h0,
		KEY_HI_HALF = 3'h1,
		KEY_HI_OPEN = 3'h2,
		KEY_LO_HALF = 3'h3,
		KEY_LO_OPEN = 3'h4
	} ckss_key_t;

	function automatic ckss_osc_t osc_of(input logic [2:0] s);
		ckss_osc_t o;
		o = OSC_FAST_RC;
		if (s == SRC_PRIMARY || s == SRC_PRIMARY_MUL) o = OSC_PRIMARY;
		else if (s == SRC_SECONDARY) o = OSC_SECONDARY;
		else if (s == SRC_LOW_POWER_RC) o = OSC_LOW_POWER_RC;
		return o;
	endfunction

	function automatic logic uses_mul(input logic [2:0] s);
		return s == SRC_FAST_RC_MUL || s == SRC_PRIMARY_MUL;
	endfunction

	function automatic logic is_crystal(input logic [2:0] s);
		return s == SRC_PRIMARY || s == SRC_PRIMARY_MUL ||
			s == SRC_SECONDARY;
	endfunction

	function automatic logic src_valid(input logic [2:0] s);
		return s <= SRC_LOW_POWER_RC;
	endfunction
endpackage

// ==== core/ckss_tick_count.sv ====
// counter of new-clock ticks with a registered done flag
`timescale 1ns/10ps
module ckss_tick_count #(
	parameter int W = 11
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         start,
	input  wire logic [W-1:0] target,
	input  wire logic         tick,
	output logic              done_q
);
	logic [W-1:0] cnt_q;

	if (W < 4) begin : g_bad_width
		$error("tick counter narrower than the settle count");
	end

	// restart wins over a tick in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (start) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (tick && !done_q) begin
			cnt_q  <= cnt_q + 1'b1;
			done_q <= (cnt_q + 1'b1) == target;
		end
	end
endmodule // ckss_tick_count

// ==== sim/ckss_switch_ctrl_tb_top.sv ====
// self-checking bench of the clock switch sequencer
`timescale 1ns/10ps
module ckss_switch_ctrl_tb_top;
	import ckss_pkg::*;
	logic        ref_clk = 1'h0, rst_b = 1'h0, en_b = 1'h0, tgl = 1'h0;
	logic        wdt = 1'h0, cf = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, d;
	logic [3:0]  wstrb = 4'h0, osc_en;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        pll_en, fsm_en, slp, irq;
	logic [1:0]  bresp, rresp, r, pmode = 2'h1;
	logic [2:0]  st_src = 3'h0;
	ckss_src_t   sys_src;
	int          n_errors = 0, comparisons = 0, m_cur, m_sts, per = 4;
	int          srcs[8] = '{3, 0, 1, 2, 5, 5, 4, 7};
	// ----------------------------------------
	// clock, new-clock ticks, dut
	// ----------------------------------------
	always #12.5 ref_clk = ~ref_clk;
	// ticks stay slower than a third of ref_clk, as the sync needs
	always begin
		repeat (per) @(posedge ref_clk);
		tgl <= ~tgl;
	end
	ckss_switch_ctrl #(.OST_TICKS(12), .CNT_W(11)) u_dut (
		.ref_clk(ref_clk), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .switch_enable_config_bit(en_b),
		.startup_source_config(st_src),
		.secondary_power_mode_field(pmode), .watchdog_timer_en(wdt),
		.osc_running(4'hF), .pll_lock(1'h1), .clock_fail(cf),
		.new_clk_toggle(tgl), .osc_en(osc_en), .pll_en(pll_en),
		.sys_clk_src(sys_src), .fail_safe_monitor_en(fsm_en),
		.secondary_low_power(slp), .irq(irq));
	// ----------------------------------------
	// compare, bus tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dd,
			input logic [3:0] s, input logic [1:0] er);
		bit ta, tw;
		ta = 0;
		tw = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= dd;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ta && tw)) begin
			@(posedge ref_clk);
			if (!ta && awready === 1'h1) begin
				ta = 1;
				awvalid <= 1'h0;
			end
			if (!tw && wready === 1'h1) begin
				tw = 1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge ref_clk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dd,
			output logic [1:0] rr);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge ref_clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		while (rvalid !== 1'h1) @(posedge ref_clk);
		dd = rdata;
		rr = rresp;
		rready <= 1'h0;
	endtask
	function automatic int ox(input int s);
		return s < 2 ? 2 : s < 4 ? 0 : s == 4 ? 1 : 3;
	endfunction
	// high key pair, source, low key pair, then the request bit
	task automatic unl(input int s);
		wr(8'h08, 32'h0000_0000, 4'h1, 2'h0);
		wr(8'h00, 32'h0000_7800, 4'h2, 2'h0);
		wr(8'h00, 32'h0000_9A00, 4'h2, 2'h0);
		wr(8'h00, s << 8, 4'h2, 2'h0);
		wr(8'h00, 32'h0000_0046, 4'h1, 2'h0);
		wr(8'h00, 32'h0000_0057, 4'h1, 2'h0);
		wr(8'h00, 32'h0000_0001, 4'h1, 2'h0);
		wr(8'h08, 32'h0000_0001, 4'h1, 2'h0);
	endtask
	task automatic sw(input int s);
		int i, o;
		o = m_cur;
		per = 4 + $urandom % 4;
		unl(s);
		d = 32'h0000_0001;
		for (i = 0; i < 300 && d[0] !== 1'h0; i++) rd(8'h00, d, r);
		m_sts = (s == m_cur || s > 5) ? 2 : 1;
		if (m_sts == 1) m_cur = s;
		chk("request", 0, d[0]);
		chk("current", m_cur, d[14:12]);
		if (m_sts == 1) begin
			chk("lock", s == 1 || s == 3, d[5]);
			chk("fail_clr", 0, d[3]);
			chk("new_osc", 1, osc_en[ox(s)]);
			if (ox(o) != ox(s)) chk("old_osc", ox(o) == 3, osc_en[ox(o)]);
		end
		chk("sys_src", m_cur, sys_src);
		rd(8'h04, d, r);
		chk("status", m_sts, d);
		chk("irq", m_sts == 1, irq);
		wr(8'h04, 32'h0000_0007, 4'h1, 2'h0);
		repeat (2) @(posedge ref_clk);
		chk("irq_clr", 0, irq);
		$display("test switch %0d done", s);
	endtask
	task automatic end_sim;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#(25 * 60000);
		n_errors++;
		end_sim;
	end
	initial begin
		void'($urandom(66946));
		m_cur = 0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (8) @(posedge ref_clk);
		rd(8'h20, d, r);
		chk("unmapped_resp", 2, r);
		chk("unmapped_data", 0, d);
		wr(8'h20, 32'h0000_0001, 4'hF, 2'h2);
		// locked write must not land
		wr(8'h00, 32'h0000_0500, 4'h2, 2'h0);
		rd(8'h00, d, r);
		chk("locked_req", 0, d[10:8]);
		rd(8'h0C, d, r);
		chk("config", 32'h0000_0008, d);
		chk("fsm_en", 1, fsm_en);
		chk("secondary_oscillator_lp", 1, slp);
		wr(8'h08, 32'h0000_0001, 4'h1, 2'h0);
		// clock failure: sticky flag and status event
		cf <= 1'h1;
		repeat (6) @(posedge ref_clk);
		cf <= 1'h0;
		repeat (4) @(posedge ref_clk);
		rd(8'h04, d, r);
		chk("fail_sts", 4, d);
		rd(8'h00, d, r);
		chk("fail_flag", 1, d[3]);
		wr(8'h04, 32'h0000_0004, 4'h1, 2'h0);
		$display("test access done");
		foreach (srcs[k]) sw(srcs[k]);
		// switching disabled by strap
		rst_b <= 1'h0;
		en_b <= 1'h1;
		wdt <= 1'h1;
		st_src <= 3'h4;
		pmode <= 2'h0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (8) @(posedge ref_clk);
		unl(0);
		repeat (40) @(posedge ref_clk);
		rd(8'h00, d, r);
		chk("dis_cur", 4, d[14:12]);
		chk("dis_req", 0, d[0]);
		chk("dis_src", 4, sys_src);
		chk("dis_fsm", 0, fsm_en);
		chk("dis_lp", 0, slp);
		chk("dis_wdt", 1, osc_en[3]);
		$display("test disabled done");
		end_sim;
	end
endmodule // ckss_switch_ctrl_tb_top
